// ---- design/cfg_defines.svh ----
// Register indices, field positions, masks and reset values of the chip-level bank
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH
`define CFG_IDX_CTRL 8'h02
`define CFG_IDX_INDEX_ADDR 8'h03
`define CFG_IDX_LDN 8'h07
`define CFG_IDX_CHIP_ID 8'h20
`define CFG_IDX_CHIP_REV 8'h21
`define CFG_IDX_PWR_EN 8'h22
`define CFG_IDX_PWR_MGMT 8'h23
`define CFG_IDX_OSC 8'h24
`define CFG_IDX_RSVD_25 8'h25
`define CFG_IDX_ADDR_LO 8'h26
`define CFG_IDX_ADDR_HI 8'h27
`define CFG_IDX_RSVD_28 8'h28
`define CFG_IDX_ACTIVATE 8'h30
`define CFG_RST_ZERO 8'h00
`define CFG_RST_INDEX_ADDR 8'h03
`define CFG_RST_OSC 8'h04
`define CFG_RST_ADDR_LO_S0 8'hf0
`define CFG_RST_ADDR_LO_S1 8'h70
`define CFG_RST_ADDR_HI 8'h03
`define CFG_MASK_PWR 8'h39
`define CFG_MASK_OSC 8'h4e
`define CFG_MASK_ADDR_LO 8'hfe
`define CFG_BIT_SOFT_RST 0
`define CFG_BIT_PLL_OFF 1
`define CFG_OSC_HI 3
`define CFG_OSC_LO 2
`define CFG_OSC_STOP 2'h3
`define CFG_BIT_QUAL16 6
`define CFG_BIT_ACTIVATE 0
`define CFG_QUAL12_MASK 16'h0fff
`define CFG_QUAL16_MASK 16'hffff
`endif

// ---- design/cfg_pkg.sv ----
// Types shared by the chip-level configuration bank
package cfg_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } host_io_t;

    typedef enum {
        PORT_NONE,
        PORT_INDEX,
        PORT_DATA
    } port_sel_t;
endpackage : cfg_pkg

// ---- design/chip_global_config_registers.sv ----
// Chip-level configuration register bank behind the index and data ports
`timescale 1ns/1ps
`include "cfg_defines.svh"

// How it works
// RULE1: All eight index bits select a register; no partial decode aliasing.
// RULE2: Unimplemented registers and bits drop writes and read back as zero.
// RULE3: Index port write picks a register; data port access then reaches it.
// RULE4: Index and data accesses act only while configuration mode is on.
// RULE5: Reserved indices drop writes and read all zeros.
// RULE6: Writing one to bit 0 of 0x02 soft-resets; bit self-clears.
// RULE7: Soft reset loads only registers that own a soft-reset value.
// RULE8: Register 0x07 selects the logical device for the per-device range.
// RULE9: Activate acts only on the currently selected logical device.
// RULE10: Register 0x20 is a fixed read-only identification byte.
// RULE11: Register 0x21 is a fixed read-only silicon revision byte.
// RULE12: Register 0x22 holds function power enables in bits 0, 3, 4, 5.
// RULE13: Power enables clear on every reset kind, soft reset included.
// RULE14: Register 0x23 holds power-management bits, same layout, not soft reset.
// RULE15: Bit 1 of 0x24 turns the PLL off when one.
// RULE16: Bits 3:2 of 0x24 equal to 11 stop oscillator and baud clock.
// RULE17: Bit 6 of 0x24 picks 16-bit rather than 12-bit address qualification.
// RULE18: Register 0x24 resets to 0x04; bits 5:4 are kept zero.
// RULE19: Register 0x26 holds address bits 7:1, bit 0 zero, strap default.
// RULE20: Register 0x27 holds address bits 15:8, resets to 0x03.
// RULE21: Writing the high byte moves the ports at once.
// RULE22: Port address resets only on hard or main power-on reset.
// RULE23: Index port sits at the configured address, data port one above.
module chip_global_config_registers #(
    parameter logic [7:0] CHIP_ID = 8'h5a,  // Arbitrary value
    parameter logic [7:0] CHIP_REV = 8'h01, // Arbitrary value
    parameter int NUM_DEV = 9,
    parameter int LDN_W = 4
) (
    // Clock, enable and resets
    input wire logic clk,
    input wire logic ce,
    input wire logic sys_rst,
    input wire logic standby_por,
    input wire logic hard_rst,
    // Mode and strap
    input wire logic cfg_mode,
    input wire logic strap_sel,
    // Host I/O cycle
    input wire cfg_pkg::host_io_t host,
    output logic [7:0] rd_data_q,
    output logic rd_valid_q,
    // Configuration outputs
    output logic [7:0] ldn_q,
    output logic [NUM_DEV-1:0] device_active_q,
    output logic [7:0] power_enable_q,
    output logic [7:0] power_mgmt_q,
    output logic [7:0] osc_ctl_q,
    output logic pll_off_q,
    output logic osc_stop_q,
    output logic [15:0] cfg_base_q,
    output logic soft_reset_q
);

    logic strap_s1_q;
    logic strap_s2_q;
    logic [7:0] index_q;
    logic [7:0] index_addr_q;
    logic [7:0] addr_lo_q;
    logic [7:0] addr_hi_q;
    logic [7:0] rd_mux;
    logic [7:0] addr_lo_dflt;
    logic [NUM_DEV-1:0] sel_mask;
    cfg_pkg::port_sel_t sel;
    logic full_rst;
    logic any_por;
    logic idx_wr;
    logic idx_rd;
    logic dat_wr;
    logic dat_rd;
    logic soft_now;
    logic rsvd_idx;
    localparam logic [7:0] OSC_RST = `CFG_RST_OSC;

    function automatic cfg_pkg::port_sel_t port_decode(input logic [15:0] a,
                                                       input logic [15:0] base,
                                                       input logic q16);
        logic [15:0] m;
        m = q16 ? `CFG_QUAL16_MASK : `CFG_QUAL12_MASK;
        if ((a & m) == (base & m)) begin
            port_decode = cfg_pkg::PORT_INDEX;
        end else if ((a & m) == ({base[15:1], 1'b1} & m)) begin
            port_decode = cfg_pkg::PORT_DATA;
        end else begin
            port_decode = cfg_pkg::PORT_NONE;
        end
    endfunction : port_decode

    function automatic logic [7:0] keep_bits(input logic [7:0] d, input logic [7:0] m);
        keep_bits = d & m;
    endfunction : keep_bits

    // Reset groups
    assign full_rst = sys_rst || hard_rst;
    assign any_por = full_rst || standby_por;

    // Port decode and access strobes
    assign sel = port_decode(host.addr, cfg_base_q, osc_ctl_q[`CFG_BIT_QUAL16]); // RULE17 RULE23
    assign idx_wr = ce && cfg_mode && host.wr && (sel == cfg_pkg::PORT_INDEX); // RULE4
    assign idx_rd = ce && cfg_mode && host.rd && (sel == cfg_pkg::PORT_INDEX); // RULE4
    assign dat_wr = ce && cfg_mode && host.wr && (sel == cfg_pkg::PORT_DATA); // RULE4 RULE3
    assign dat_rd = ce && cfg_mode && host.rd && (sel == cfg_pkg::PORT_DATA); // RULE4 RULE3
    assign soft_now = dat_wr && (index_q == `CFG_IDX_CTRL)
                      && host.wdata[`CFG_BIT_SOFT_RST]; // RULE6
    assign sel_mask = (ldn_q < 8'(NUM_DEV))
                      ? ({{(NUM_DEV-1){1'b0}}, 1'b1} << ldn_q[LDN_W-1:0]) : '0; // RULE9
    assign addr_lo_dflt = strap_s2_q ? `CFG_RST_ADDR_LO_S1 : `CFG_RST_ADDR_LO_S0; // RULE19
    assign rsvd_idx = (index_q < `CFG_IDX_INDEX_ADDR)
                      || ((index_q > `CFG_IDX_INDEX_ADDR) && (index_q < `CFG_IDX_LDN))
                      || ((index_q > `CFG_IDX_LDN) && (index_q < `CFG_IDX_CHIP_ID))
                      || (index_q == `CFG_IDX_RSVD_25)
                      || ((index_q >= `CFG_IDX_RSVD_28) && (index_q < `CFG_IDX_ACTIVATE));

    // Strap synchroniser
    always_ff @(posedge clk) begin
        strap_s1_q <= strap_sel;
        strap_s2_q <= strap_s1_q;
    end

    // Index pointer
    always_ff @(posedge clk) begin
        if (any_por) begin
            index_q <= `CFG_RST_ZERO;
        end else if (idx_wr) begin
            index_q <= host.wdata; // RULE1 RULE3
        end
    end

    // Soft reset pulse to the logical devices
    always_ff @(posedge clk) begin
        if (any_por) begin
            soft_reset_q <= 1'b0;
        end else if (ce) begin
            soft_reset_q <= soft_now; // RULE6
        end
    end

    // Index address register
    always_ff @(posedge clk) begin
        if (any_por) begin
            index_addr_q <= `CFG_RST_INDEX_ADDR;
        end else if (dat_wr && index_q == `CFG_IDX_INDEX_ADDR) begin
            index_addr_q <= host.wdata;
        end
    end

    // Logical device select
    always_ff @(posedge clk) begin
        if (any_por) begin
            ldn_q <= `CFG_RST_ZERO;
        end else if (dat_wr && index_q == `CFG_IDX_LDN) begin
            ldn_q <= host.wdata; // RULE8
        end
    end

    // Activate bits of the logical devices
    always_ff @(posedge clk) begin
        if (any_por || soft_now) begin
            device_active_q <= '0; // RULE7
        end else if (dat_wr && index_q == `CFG_IDX_ACTIVATE) begin
            device_active_q <= (device_active_q & ~sel_mask)
                               | (host.wdata[`CFG_BIT_ACTIVATE] ? sel_mask : '0); // RULE9
        end
    end

    // Function power enables
    always_ff @(posedge clk) begin
        if (any_por || soft_now) begin
            power_enable_q <= `CFG_RST_ZERO; // RULE13 RULE7
        end else if (dat_wr && index_q == `CFG_IDX_PWR_EN) begin
            power_enable_q <= keep_bits(host.wdata, `CFG_MASK_PWR); // RULE12 RULE2
        end
    end

    // Function power management
    always_ff @(posedge clk) begin
        if (any_por) begin
            power_mgmt_q <= `CFG_RST_ZERO; // RULE14
        end else if (dat_wr && index_q == `CFG_IDX_PWR_MGMT) begin
            power_mgmt_q <= keep_bits(host.wdata, `CFG_MASK_PWR); // RULE14 RULE2
        end
    end

    // Oscillator, PLL and address qualification
    always_ff @(posedge clk) begin
        if (any_por) begin
            osc_ctl_q <= `CFG_RST_OSC; // RULE18
        end else if (dat_wr && index_q == `CFG_IDX_OSC) begin
            osc_ctl_q <= keep_bits(host.wdata, `CFG_MASK_OSC); // RULE18 RULE2
        end
    end

    // Decoded clock controls
    always_ff @(posedge clk) begin
        if (any_por) begin
            pll_off_q <= OSC_RST[`CFG_BIT_PLL_OFF];
            osc_stop_q <= (OSC_RST[`CFG_OSC_HI:`CFG_OSC_LO] == `CFG_OSC_STOP);
        end else if (ce) begin
            pll_off_q <= osc_ctl_q[`CFG_BIT_PLL_OFF]; // RULE15
            osc_stop_q <= (osc_ctl_q[`CFG_OSC_HI:`CFG_OSC_LO] == `CFG_OSC_STOP); // RULE16
        end
    end

    // Configuration address bytes
    always_ff @(posedge clk) begin
        if (full_rst) begin
            addr_lo_q <= addr_lo_dflt; // RULE19 RULE22
        end else if (dat_wr && index_q == `CFG_IDX_ADDR_LO) begin
            addr_lo_q <= keep_bits(host.wdata, `CFG_MASK_ADDR_LO); // RULE19
        end
    end

    always_ff @(posedge clk) begin
        if (full_rst) begin
            addr_hi_q <= `CFG_RST_ADDR_HI; // RULE20 RULE22
        end else if (dat_wr && index_q == `CFG_IDX_ADDR_HI) begin
            addr_hi_q <= host.wdata; // RULE20
        end
    end

    // Live port base, moved by the high byte write
    always_ff @(posedge clk) begin
        if (full_rst) begin
            cfg_base_q <= {`CFG_RST_ADDR_HI, addr_lo_dflt}; // RULE22
        end else if (dat_wr && index_q == `CFG_IDX_ADDR_HI) begin
            cfg_base_q <= {host.wdata, addr_lo_q}; // RULE21
        end
    end

    // Read data select
    always_comb begin
        case (index_q)
            `CFG_IDX_INDEX_ADDR: rd_mux = index_addr_q;
            `CFG_IDX_LDN: rd_mux = ldn_q;
            `CFG_IDX_CHIP_ID: rd_mux = CHIP_ID; // RULE10
            `CFG_IDX_CHIP_REV: rd_mux = CHIP_REV; // RULE11
            `CFG_IDX_PWR_EN: rd_mux = power_enable_q;
            `CFG_IDX_PWR_MGMT: rd_mux = power_mgmt_q;
            `CFG_IDX_OSC: rd_mux = osc_ctl_q;
            `CFG_IDX_ADDR_LO: rd_mux = addr_lo_q;
            `CFG_IDX_ADDR_HI: rd_mux = addr_hi_q;
            `CFG_IDX_ACTIVATE: rd_mux = {7'h00, |(device_active_q & sel_mask)};
            default: rd_mux = `CFG_RST_ZERO; // RULE5 RULE2
        endcase
    end

    // Read answer
    always_ff @(posedge clk) begin
        if (any_por) begin
            rd_data_q <= `CFG_RST_ZERO;
        end else if (idx_rd) begin
            rd_data_q <= index_q;
        end else if (dat_rd) begin
            rd_data_q <= rd_mux; // RULE3
        end
    end

    always_ff @(posedge clk) begin
        if (any_por) begin
            rd_valid_q <= 1'b0;
        end else if (ce) begin
            rd_valid_q <= idx_rd || dat_rd;
        end
    end

    // Checks
    idx_capture_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        idx_wr && !hard_rst && !standby_por |=> index_q == $past(host.wdata))
        else $error("index port write not captured in full");

    rsvd_read_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
        dat_rd && rsvd_idx && !hard_rst && !standby_por |=> rd_valid_q && rd_data_q == 8'h00)
        else $error("reserved register read not zero");

    rsvd_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE2
        dat_wr && index_q == `CFG_IDX_RSVD_25 |=> $stable(power_enable_q)
        && $stable(power_mgmt_q) && $stable(osc_ctl_q) && $stable(ldn_q))
        else $error("reserved register write changed state");

    data_route_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE3
        idx_wr && !hard_rst && !standby_por ##[1:2] dat_rd && !hard_rst && !standby_por
        && index_q == `CFG_IDX_LDN |=> rd_valid_q && rd_data_q == ldn_q)
        else $error("data port read did not reach selected register");

    ldn_write_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
        dat_wr && index_q == `CFG_IDX_LDN && !hard_rst && !standby_por
        |=> ldn_q == $past(host.wdata))
        else $error("logical device select not written");

    mode_gate_a: assert property (@(posedge clk) // RULE4
        disable iff (sys_rst || hard_rst || standby_por)
        !cfg_mode |=> $stable(index_q) && $stable(ldn_q) && $stable(power_mgmt_q)
        && !rd_valid_q)
        else $error("access outside configuration mode took effect");

    soft_pulse_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst) // RULE6
        soft_now && !standby_por |=> soft_reset_q && index_q == $past(index_q))
        else $error("soft reset pulse missing");

    soft_scope_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst) // RULE7
        soft_now && !standby_por |=> power_enable_q == 8'h00 && device_active_q == '0
        && osc_ctl_q == $past(osc_ctl_q) && power_mgmt_q == $past(power_mgmt_q)
        && cfg_base_q == $past(cfg_base_q) && ldn_q == $past(ldn_q))
        else $error("soft reset scope wrong");

    activate_sel_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
        dat_wr && index_q == `CFG_IDX_ACTIVATE && !hard_rst && !standby_por
        |=> ((device_active_q ^ $past(device_active_q)) & ~$past(sel_mask)) == '0)
        else $error("activate touched an unselected device");

    chip_id_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE10
        dat_rd && index_q == `CFG_IDX_CHIP_ID && !hard_rst && !standby_por
        |=> rd_data_q == CHIP_ID)
        else $error("identification read wrong");

    chip_rev_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
        dat_rd && index_q == `CFG_IDX_CHIP_REV && !hard_rst && !standby_por
        |=> rd_data_q == CHIP_REV)
        else $error("revision read wrong");

    power_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
        (power_enable_q & ~`CFG_MASK_PWR) == 8'h00)
        else $error("reserved power enable bit set");

    power_reset_a: assert property (@(posedge clk) // RULE13
        hard_rst || standby_por || sys_rst |=> power_enable_q == 8'h00)
        else $error("power enables not cleared by reset");

    mgmt_bits_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
        power_mgmt_q[7:6] == 2'h0)
        else $error("power management high bits set");

    pll_follow_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst || standby_por) // RULE15
        ce && dat_wr && index_q == `CFG_IDX_OSC ##1 ce
        |=> pll_off_q == $past(host.wdata[`CFG_BIT_PLL_OFF], 2))
        else $error("PLL control not followed");

    osc_stop_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst || standby_por) // RULE16
        ce |=> osc_stop_q == ($past(osc_ctl_q[`CFG_OSC_HI:`CFG_OSC_LO]) == `CFG_OSC_STOP))
        else $error("oscillator stop decode wrong");

    qual12_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst || standby_por) // RULE17
        ce && cfg_mode && host.wr && !osc_ctl_q[`CFG_BIT_QUAL16]
        && host.addr[11:0] == cfg_base_q[11:0] |=> index_q == $past(host.wdata))
        else $error("12-bit qualified index write missed");

    osc_reset_a: assert property (@(posedge clk) // RULE18
        hard_rst || standby_por || sys_rst |=> osc_ctl_q == 8'h04 ##1 osc_ctl_q[5:4] == 2'h0)
        else $error("oscillator control reset wrong");

    addr_lo_bit0_a: assert property (@(posedge clk) disable iff (sys_rst) // RULE19
        addr_lo_q[0] == 1'b0 && cfg_base_q[0] == 1'b0)
        else $error("configuration address bit 0 set");

    addr_hi_rst_a: assert property (@(posedge clk) // RULE20
        hard_rst |=> addr_hi_q == 8'h03 && cfg_base_q[15:8] == 8'h03)
        else $error("configuration high byte reset wrong");

    base_move_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst) // RULE21
        dat_wr && index_q == `CFG_IDX_ADDR_HI |=> cfg_base_q == {$past(host.wdata),
        $past(addr_lo_q)})
        else $error("high byte write did not move ports");

    base_hold_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst) // RULE21
        dat_wr && index_q == `CFG_IDX_ADDR_LO |=> $stable(cfg_base_q))
        else $error("low byte write moved ports");

    base_keep_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst) // RULE22
        standby_por || soft_now |=> $stable(cfg_base_q) && $stable(addr_hi_q))
        else $error("port address lost on standby or soft reset");

    data_port_a: assert property (@(posedge clk) disable iff (sys_rst || hard_rst || standby_por) // RULE23
        ce && cfg_mode && host.rd && host.addr == {cfg_base_q[15:1], 1'b1}
        && index_q == `CFG_IDX_OSC |=> rd_valid_q && rd_data_q == osc_ctl_q)
        else $error("data port not at base plus one");

endmodule : chip_global_config_registers

// ---- test/host_io_model.sv ----
// Host bus master reaching the bank through the index and data ports
`timescale 1ns/1ps
module host_io_model (
    // Clock
    input wire logic clk,
    // Host I/O cycle
    output cfg_pkg::host_io_t host,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q
);
    logic [15:0] base = 16'h03f0;
    logic [7:0] lo = 8'hf0;

    initial host = '0;

    // One-cycle request; released lines show inverted values
    task automatic io(input logic wr, input logic rd, input logic [15:0] addr,
            input logic [7:0] wdata, output logic [7:0] rdata, output logic got);
        @(negedge clk);
        host = {wr, rd, addr, wdata};
        @(negedge clk);
        got = rd_valid_q;
        rdata = rd_data_q;
        host = {1'b0, 1'b0, ~addr, ~wdata};
    endtask : io

    task automatic set_home(input logic [15:0] a);
        base = a;
        lo = a[7:0];
    endtask : set_home

    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] data);
        logic [7:0] dd;
        logic gg;
        io(1'b1, 1'b0, base, idx, dd, gg);
        io(1'b1, 1'b0, base | 16'h0001, data, dd, gg);
        if (idx == 8'h26) begin
            lo = data & 8'hfe;
        end
        if (idx == 8'h27) begin
            base = {data, lo};
        end
    endtask : cfg_wr

    task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] rdata, output logic got);
        io(1'b1, 1'b0, base, idx, rdata, got);
        io(1'b0, 1'b1, base | 16'h0001, 8'h00, rdata, got);
    endtask : cfg_rd
endmodule : host_io_model

// ---- test/test_chip_global_config_registers.sv ----
// Self-checking bench for the chip-level configuration bank
`timescale 1ns/1ps
module test_chip_global_config_registers;
    logic clk = 1'b0;
    logic ce = 1'b1;
    logic sys_rst = 1'b1;
    logic standby_por = 1'b0;
    logic hard_rst = 1'b0;
    logic cfg_mode = 1'b1;
    logic strap_sel = 1'b0;
    cfg_pkg::host_io_t host;
    logic [7:0] rd_data_q, ldn_q, power_enable_q, power_mgmt_q, osc_ctl_q, d;
    logic rd_valid_q, pll_off_q, osc_stop_q, soft_reset_q, g;
    logic [8:0] device_active_q;
    logic [15:0] cfg_base_q;
    logic [7:0] rsvd [12] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h1f, 8'h25,
        8'h28, 8'h29, 8'h2a, 8'ha2};
    int failures = 0;
    int compares = 0;

    always #20 clk = ~clk;

    // Identification values are arbitrary
    chip_global_config_registers #(.CHIP_ID(8'ha6), .CHIP_REV(8'h3c))
            i_chip_global_config_registers (
        .clk(clk), .ce(ce), .sys_rst(sys_rst), .standby_por(standby_por),
        .hard_rst(hard_rst), .cfg_mode(cfg_mode), .strap_sel(strap_sel), .host(host),
        .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .ldn_q(ldn_q),
        .device_active_q(device_active_q), .power_enable_q(power_enable_q),
        .power_mgmt_q(power_mgmt_q), .osc_ctl_q(osc_ctl_q), .pll_off_q(pll_off_q),
        .osc_stop_q(osc_stop_q), .cfg_base_q(cfg_base_q), .soft_reset_q(soft_reset_q));

    host_io_model i_host_io_model (.clk(clk), .host(host), .rd_data_q(rd_data_q),
        .rd_valid_q(rd_valid_q));

    task automatic end_sim;
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic rd_exp(input logic [7:0] idx, input logic [7:0] exp);
        i_host_io_model.cfg_rd(idx, d, g);
        check({7'h00, g, d}, {8'h01, exp}, $sformatf("read index %h", idx));
    endtask : rd_exp

    task automatic do_reset(input int kind, input logic strap);
        strap_sel = strap;
        sys_rst = (kind == 0);
        standby_por = (kind == 1);
        hard_rst = (kind == 2);
        repeat (4) @(negedge clk);
        {sys_rst, standby_por, hard_rst} = 3'h0;
        if (kind != 1) begin
            i_host_io_model.set_home(strap ? 16'h0370 : 16'h03f0);
        end
    endtask : do_reset

    task automatic t_reset_values;
        check(cfg_base_q, 16'h03f0, "base after reset");
        rd_exp(8'h24, 8'h04);
        rd_exp(8'h26, 8'hf0);
        rd_exp(8'h27, 8'h03);
        rd_exp(8'h03, 8'h03);
        rd_exp(8'h07, 8'h00);
        rd_exp(8'h22, 8'h00);
        i_host_io_model.cfg_wr(8'h20, 8'hff);
        i_host_io_model.cfg_wr(8'h21, 8'hff);
        rd_exp(8'h20, 8'ha6);
        rd_exp(8'h21, 8'h3c);
    endtask : t_reset_values

    task automatic t_masks;
        i_host_io_model.cfg_wr(8'h22, 8'hff);
        rd_exp(8'h22, 8'h39);
        check(16'(power_enable_q), 16'h0039, "power enable");
        i_host_io_model.cfg_wr(8'h23, 8'hff);
        rd_exp(8'h23, 8'h39);
        check(16'(power_mgmt_q), 16'h0039, "power management");
        i_host_io_model.cfg_wr(8'h24, 8'hff);
        @(negedge clk);
        rd_exp(8'h24, 8'h4e);
        check(16'(osc_ctl_q), 16'h004e, "oscillator control");
        check({pll_off_q, osc_stop_q}, 16'h0003, "pll and osc off");
        for (int v = 0; v < 4; v++) begin
            i_host_io_model.cfg_wr(8'h24, {4'h0, 2'(v), 2'h0});
            @(negedge clk);
            check({pll_off_q, osc_stop_q}, 16'(v == 3), "osc field");
        end
    endtask : t_masks

    task automatic t_reserved;
        foreach (rsvd[i]) begin
            i_host_io_model.cfg_wr(rsvd[i], 8'hfe);
            rd_exp(rsvd[i], 8'h00);
        end
        rd_exp(8'h22, 8'h39);
    endtask : t_reserved

    task automatic t_activate;
        i_host_io_model.cfg_wr(8'h07, 8'h02);
        i_host_io_model.cfg_wr(8'h30, 8'h01);
        check(16'(device_active_q), 16'h0004, "activate two");
        i_host_io_model.cfg_wr(8'h07, 8'h05);
        i_host_io_model.cfg_wr(8'h30, 8'h01);
        check(16'(device_active_q), 16'h0024, "activate five");
        rd_exp(8'h07, 8'h05);
        check(16'(ldn_q), 16'h0005, "device select");
        rd_exp(8'h30, 8'h01);
        i_host_io_model.cfg_wr(8'h07, 8'h02);
        i_host_io_model.cfg_wr(8'h30, 8'h00);
        check(16'(device_active_q), 16'h0020, "deactivate two");
        i_host_io_model.cfg_wr(8'h07, 8'h0c);
        i_host_io_model.cfg_wr(8'h30, 8'h01);
        check(16'(device_active_q), 16'h0020, "absent device");
        i_host_io_model.cfg_wr(8'h07, 8'h12);
        i_host_io_model.cfg_wr(8'h30, 8'h01);
        check(16'(device_active_q), 16'h0020, "wide device number");
        rd_exp(8'h30, 8'h00);
    endtask : t_activate

    task automatic t_soft;
        i_host_io_model.cfg_wr(8'h07, 8'h03);
        i_host_io_model.cfg_wr(8'h30, 8'h01);
        i_host_io_model.cfg_wr(8'h02, 8'h01);
        check({soft_reset_q, power_enable_q}, 16'h0100, "soft pulse");
        check(16'(device_active_q), 16'h0000, "soft active");
        @(negedge clk);
        check(16'(soft_reset_q), 16'h0000, "soft pulse end");
        rd_exp(8'h23, 8'h39);
        rd_exp(8'h07, 8'h03);
        rd_exp(8'h24, 8'h0c);
        rd_exp(8'h02, 8'h00);
    endtask : t_soft

    task automatic t_refused;
        for (int k = 0; k < 2; k++) begin
            {ce, cfg_mode} = k ? 2'b01 : 2'b10;
            i_host_io_model.io(1'b1, 1'b0, 16'h03f0, 8'h22, d, g);
            i_host_io_model.io(1'b1, 1'b0, 16'h03f1, 8'hff, d, g);
            i_host_io_model.io(1'b0, 1'b1, 16'h03f1, 8'h00, d, g);
            check({g, power_enable_q}, 16'h0000, "refused access");
        end
        {ce, cfg_mode} = 2'b11;
    endtask : t_refused

    task automatic t_qual;
        i_host_io_model.io(1'b1, 1'b0, 16'hf3f0, 8'h22, d, g);
        i_host_io_model.io(1'b1, 1'b0, 16'hf3f1, 8'h01, d, g);
        check(16'(power_enable_q), 16'h0001, "12-bit alias");
        i_host_io_model.cfg_wr(8'h24, 8'h4c);
        i_host_io_model.io(1'b1, 1'b0, 16'hf3f0, 8'h22, d, g);
        i_host_io_model.io(1'b1, 1'b0, 16'hf3f1, 8'h20, d, g);
        check(16'(power_enable_q), 16'h0001, "16-bit alias");
    endtask : t_qual

    task automatic t_relocate;
        i_host_io_model.cfg_wr(8'h26, 8'h51);
        rd_exp(8'h26, 8'h50);
        check(cfg_base_q, 16'h03f0, "low byte alone");
        i_host_io_model.cfg_wr(8'h27, 8'h12);
        check(cfg_base_q, 16'h1250, "moved base");
        rd_exp(8'h22, 8'h01);
        i_host_io_model.io(1'b0, 1'b1, 16'h03f1, 8'h00, d, g);
        check(16'(g), 16'h0000, "old data port");
        do_reset(1, 1'b0);
        check(cfg_base_q, 16'h1250, "standby keeps base");
        rd_exp(8'h22, 8'h00);
        rd_exp(8'h24, 8'h04);
        do_reset(2, 1'b0);
        check(cfg_base_q, 16'h03f0, "hard reset base");
        do_reset(0, 1'b1);
        check(cfg_base_q, 16'h0370, "strap base");
        rd_exp(8'h26, 8'h70);
    endtask : t_relocate

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        end_sim();
    end

    initial begin
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        t_reset_values();
        t_masks();
        t_reserved();
        t_activate();
        t_soft();
        t_refused();
        t_qual();
        t_relocate();
        end_sim();
    end
endmodule : test_chip_global_config_registers
